//--- verilog/acps_pkg.sv
// Constants and types shared by the converter sequencer files.
package acps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_NS = 5;
  // Internal start pulse; a least time, so round up
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Conversion time; a fixed figure, rounded down
  localparam int CONV_NS = 4500;
  localparam int CONV_CYC = CONV_NS / CLK_PERIOD_NS;
  // Acquisition the host must allow after busy falls
  localparam int ACQ_NS = 100;
  localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Resolution and step timing
  localparam int RES_BITS = 8;
  localparam int BIT_CYC = CONV_CYC / RES_BITS;
  localparam int PULSE_W = 8;
  localparam int STEP_W = 7;
  localparam int IDX_W = 3;
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYC - 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(BIT_CYC - 1);
  localparam logic [RES_BITS-1:0] TRIAL_MSB = 8'h80;
  localparam logic [RES_BITS-1:0] RESULT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Power state
  typedef enum logic {
    ACPS_PWR_DOWN,
    ACPS_PWR_UP
  } acps_pwr_t;

endpackage : acps_pkg

//--- verilog/acps_sar.sv
// Successive-approximation stepping engine with fixed conversion time.
`timescale 1ns/1ps
module acps_sar
  import acps_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  input wire logic comp_above,
  output logic busy,
  output logic done,
  output logic [RES_BITS-1:0] dac_code,
  output logic [RES_BITS-1:0] result
);

  logic [STEP_W-1:0] step_q;
  logic [IDX_W-1:0] idx_q;
  logic [RES_BITS-1:0] keep_q;
  wire step_end = busy && (step_q == STEP_LAST);
  wire last_bit = (idx_q == IDX_W'(0));
  // Trial code is the straight binary code: one step is vref/256
  wire [RES_BITS-1:0] cur_bit = TRIAL_MSB >> (IDX_W'(RES_BITS - 1) - idx_q);
  wire [RES_BITS-1:0] decided = comp_above ? dac_code : keep_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      step_q <= '0;
      idx_q <= '0;
      keep_q <= RESULT_RST;
      dac_code <= RESULT_RST;
      result <= RESULT_RST;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        step_q <= '0;
        idx_q <= IDX_W'(RES_BITS - 1);
        keep_q <= RESULT_RST;
        dac_code <= TRIAL_MSB;
      end else if (step_end) begin
        step_q <= '0;
        keep_q <= decided;
        if (last_bit) begin
          // Fixed duration: eight equal bit steps
          busy <= 1'b0;
          done <= 1'b1;
          result <= decided;
          dac_code <= decided;
        end else begin
          idx_q <= idx_q - IDX_W'(1);
          dac_code <= decided | (cur_bit >> 1);
        end
      end else if (busy) begin
        step_q <= step_q + STEP_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  busy_done_a: assert property (
    @(posedge clock) disable iff (!resetn)
    $fell(busy) |-> done)
    else $error("busy fell without done");

endmodule : acps_sar

//--- verilog/acps_sequencer.sv
// Start, power and read control of an 8-bit sampling converter.
`timescale 1ns/1ps
module acps_sequencer
  import acps_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic comp_above,
  output logic busy,
  output logic powered,
  output logic track,
  output logic [RES_BITS-1:0] dac_code,
  output logic [RES_BITS-1:0] data_out,
  output logic data_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stages feed only second stages
  logic start_m_q, start_s_q, start_p_q;
  logic cs_m_q, cs_s_q, rd_m_q, rd_s_q;
  logic cmp_m_q, cmp_s_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {start_m_q, start_s_q, start_p_q} <= 3'h0;
      {cs_m_q, cs_s_q, rd_m_q, rd_s_q} <= 4'hf;
      {cmp_m_q, cmp_s_q} <= 2'h0;
    end else begin
      start_m_q <= convert_start_n;
      start_s_q <= start_m_q;
      start_p_q <= start_s_q;
      cs_m_q <= chip_select_n;
      cs_s_q <= cs_m_q;
      rd_m_q <= read_n;
      rd_s_q <= rd_m_q;
      cmp_m_q <= comp_above;
      cmp_s_q <= cmp_m_q;
    end
  end

  wire start_rise = start_s_q && !start_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // Internal start pulse and gated start
  logic pulse_q;
  logic [PULSE_W-1:0] pulse_cnt_q;
  logic gated_q;
  wire gated_d = start_s_q | pulse_q;
  wire gated_fall = gated_q && !gated_d;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (start_rise) begin
      // Retrigger restarts the full pulse
      pulse_q <= 1'b1;
      pulse_cnt_q <= PULSE_LOAD;
    end else if (pulse_q) begin
      pulse_cnt_q <= pulse_cnt_q - PULSE_W'(1);
      if (pulse_cnt_q == '0) begin
        pulse_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gated_q <= 1'b0;
    end else begin
      gated_q <= gated_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state
  acps_pwr_t pwr_q, pwr_d;
  logic sar_busy, sar_done;
  logic [RES_BITS-1:0] sar_result;
  wire conv_start = gated_fall && (pwr_q == ACPS_PWR_UP) && !sar_busy;

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      ACPS_PWR_DOWN: begin
        if (start_rise) begin
          pwr_d = ACPS_PWR_UP;
        end
      end
      ACPS_PWR_UP: begin
        // Sample the mode as the conversion ends
        if (sar_done && !start_s_q && !start_rise) begin
          pwr_d = ACPS_PWR_DOWN;
        end
      end
      default: pwr_d = ACPS_PWR_DOWN;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_q <= ACPS_PWR_DOWN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion engine
  acps_sar u_sar (
    .clock(clock),
    .resetn(resetn),
    .start(conv_start),
    .comp_above(cmp_s_q),
    .busy(sar_busy),
    .done(sar_done),
    .dac_code(dac_code),
    .result(sar_result)
  );

  assign busy = sar_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Track/hold, output register and read port
  logic [RES_BITS-1:0] data_q;
  wire read_on = !cs_s_q && !rd_s_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      track <= 1'b1;
      data_q <= RESULT_RST;
      data_out <= RESULT_RST;
      data_oe <= 1'b0;
      powered <= 1'b0;
    end else begin
      if (conv_start) begin
        track <= 1'b0;
      end else if (sar_done) begin
        track <= 1'b1;
      end
      if (sar_done) begin
        data_q <= sar_result;
      end
      // Data while busy is stale; the host must not read then
      data_out <= sar_done ? sar_result : data_q;
      data_oe <= read_on;
      powered <= (pwr_d == ACPS_PWR_UP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [PULSE_W:0] pulse_len_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_len_q <= '0;
    end else if (start_rise) begin
      pulse_len_q <= '0;
    end else if (pulse_q) begin
      pulse_len_q <= pulse_len_q + (PULSE_W + 1)'(1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  pulse_length_a: assert property (
    $fell(pulse_q) |-> pulse_len_q == (PULSE_W + 1)'(PULSE_CYC))
    else $error("internal pulse length wrong");

  busy_start_a: assert property (
    conv_start |=> busy && !track)
    else $error("busy not raised at conversion start");

  no_sleep_conv_a: assert property (
    !powered |-> !conv_start)
    else $error("conversion while powered down");

  wake_edge_a: assert property (
    start_rise |=> powered)
    else $error("rising start did not wake part");

  pulse_gate_a: assert property (
    pulse_q |-> !conv_start)
    else $error("conversion started during internal pulse");

  // Output register and track follow the engine's busy fall by one edge
  busy_fall_a: assert property (
    $fell(busy) |=> data_q == $past(sar_result) && data_out == data_q
      && track)
    else $error("result not latched at busy fall");

  mode_fast_a: assert property (
    sar_done && start_s_q |=> powered)
    else $error("high speed mode powered down");

  // A fresh rise right after the power-down may legally wake it again
  mode_down_a: assert property (
    sar_done && !start_s_q && !start_rise |=>
      !powered ##1 (!powered || $past(start_rise)))
    else $error("power down mode stayed powered");

  bus_drive_a: assert property (
    data_oe |-> !$past(cs_s_q) && !$past(rd_s_q))
    else $error("bus driven without read");

  start_only_gated_a: assert property (
    $rose(busy) |-> $past(gated_q, 2) && !$past(start_s_q))
    else $error("conversion without gated falling edge");

endmodule : acps_sequencer

//--- tb/acps_analog_model.sv
// Analog front end model: ideal comparator against the trial code.
`timescale 1ns/1ps
module acps_analog_model
  import acps_pkg::*;
(
  input wire logic [RES_BITS-1:0] vin_code,
  input wire logic [RES_BITS-1:0] dac_code,
  output logic comp_above
);
  // Input given as an ideal code, so one step is exactly vref/256
  assign comp_above = (vin_code >= dac_code);
endmodule : acps_analog_model

//--- tb/test_acps_sequencer.sv
// Self-checking bench for the converter start and power sequencer.
`timescale 1ns/1ps
module test_acps_sequencer
  import acps_pkg::*;
;
  logic clock;
  logic resetn;
  logic convert_start_n;
  logic chip_select_n;
  logic read_n;
  logic comp_above;
  logic busy;
  logic powered;
  logic track;
  logic [RES_BITS-1:0] dac_code;
  logic [RES_BITS-1:0] data_out;
  logic data_oe;
  logic [RES_BITS-1:0] vin_code;
  int failures;
  int checks;

  acps_sequencer uut (.clock(clock), .resetn(resetn),
    .convert_start_n(convert_start_n), .chip_select_n(chip_select_n),
    .read_n(read_n), .comp_above(comp_above), .busy(busy),
    .powered(powered), .track(track), .dac_code(dac_code),
    .data_out(data_out), .data_oe(data_oe));

  acps_analog_model analog (.vin_code(vin_code), .dac_code(dac_code),
    .comp_above(comp_above));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : chk

  function automatic logic pick(input int sel);
    return (sel == 0) ? busy : (sel == 1) ? powered : data_oe;
  endfunction : pick

  // Bounded wait; the caller judges the level reached
  task wait_on(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    #1;
    while (pick(sel) !== lvl && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : wait_on

  ////////////////////////////////////////////////////////////////////////////
  task reset_state;
    repeat (50) @(posedge clock);
    #1;
    chk("powered", 8'h00, powered);
    chk("busy", 8'h00, busy);
    chk("track", 8'h01, track);
    chk("data_oe", 8'h00, data_oe);
  endtask : reset_state

  // Short start pulse: conversion waits for the internal pulse
  task conv_mode2(input logic [7:0] v);
    @(posedge clock);
    vin_code <= v;
    convert_start_n <= 1'b1;
    @(posedge clock);
    convert_start_n <= 1'b0;
    wait_on(1, 1'b1, 10);
    chk("powered", 8'h01, powered);
    repeat (150) @(posedge clock);
    #1;
    chk("busy early", 8'h00, busy);
    wait_on(0, 1'b1, 100);
    chk("busy", 8'h01, busy);
    chk("dac_code", TRIAL_MSB, dac_code);
    chk("track", 8'h00, track);
    wait_on(0, 1'b0, 1000);
    chk("busy end", 8'h00, busy);
    // Output register and track settle one edge after busy falls
    @(posedge clock);
    #1;
    chk("result", v, data_out);
    chk("track", 8'h01, track);
    wait_on(1, 1'b0, 5);
    chk("powered", 8'h00, powered);
  endtask : conv_mode2

  // Long start pulse, then start high across conversion end
  task conv_mode1;
    @(posedge clock);
    vin_code <= 8'h3c;
    convert_start_n <= 1'b1;
    repeat (300) @(posedge clock);
    #1;
    chk("busy held", 8'h00, busy);
    @(posedge clock);
    convert_start_n <= 1'b0;
    wait_on(0, 1'b1, 10);
    chk("busy", 8'h01, busy);
    repeat (400) @(posedge clock);
    convert_start_n <= 1'b1;
    wait_on(0, 1'b0, 1000);
    @(posedge clock);
    #1;
    chk("result", 8'h3c, data_out);
    repeat (ACQ_CYC + 5) @(posedge clock);
    #1;
    chk("powered", 8'h01, powered);
    @(posedge clock);
    convert_start_n <= 1'b0;
    wait_on(0, 1'b1, 10);
    chk("busy again", 8'h01, busy);
    wait_on(0, 1'b0, 1000);
    wait_on(1, 1'b0, 5);
    chk("powered", 8'h00, powered);
  endtask : conv_mode1

  task read_port;
    @(posedge clock);
    chip_select_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk("data_oe cs only", 8'h00, data_oe);
    @(posedge clock);
    read_n <= 1'b0;
    wait_on(2, 1'b1, 5);
    chk("data_oe", 8'h01, data_oe);
    chk("data_out", 8'h3c, data_out);
    @(posedge clock);
    chip_select_n <= 1'b1;
    wait_on(2, 1'b0, 5);
    chk("data_oe off", 8'h00, data_oe);
    @(posedge clock);
    read_n <= 1'b1;
  endtask : read_port

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checks = 0;
    resetn = 1'b0;
    convert_start_n = 1'b0;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    vin_code = 8'h00;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    reset_state();
    conv_mode2(8'h00);
    conv_mode2(8'ha5);
    conv_mode2(8'hff);
    conv_mode1();
    read_port();
    test_done();
  end

  // Whole run needs about 5500 cycles
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    test_done();
  end
endmodule : test_acps_sequencer
